// ==== src/plc_core.sv ====
// address decode array, general logic array and 24 macrocells
// Notes on behaviour
// - 59 inputs, 8 selects, one term each
// - io select index passes low eight address bits
// - array sees A0, A1, A8-A15 only
// - general array shares inputs, feeds three sets
// - output pin driven by macrocell, term enable
// - input pin value routed onto array bus
// - port A: 8 cells, 3 shared terms
// - shared enable, preset and clear terms
// - port A cells OR six terms, polarity
// - registered or combinatorial, pin modes
// - port A flops clocked by clock pin
// - optional clear by configurable reset copy
// - buried cell frees pin for other use
// - feedback of flop or OR output
// - port B: 8 cells, per-cell clock, clear
// - port B cells OR ten terms, polarity
// - port B preset only when term programmed
// - port B clear: reset or own term
// - port B clock: clock pin or term
// - port E: 8 cells, one term each
// - port E shared enable, preset, clear terms
// - port E clock pin, configurable reset clear
// - term ANDs true or complemented inputs
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "plc_defs.svh"
module plc_core
    import plc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output var  logic [31:0] bus_rdata,
    input  wire logic [7:0]  port_a_in,
    input  wire logic [7:0]  port_b_in,
    input  wire logic [7:0]  port_e_in,
    input  wire logic [7:0]  port_c_in,
    input  wire logic [7:0]  port_d_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic        input_clock_pin,
    input  wire logic        reset_pin,
    input  wire logic        chip_select_in,
    input  wire logic [3:0]  page_reg,
    input  wire logic [23:0] alt_out,
    input  wire logic [23:0] alt_oe_n,
    output var  logic [23:0] pin_out,
    output var  logic [23:0] pin_oe_n,
    output var  logic [7:0]  select_out,
    output var  logic        io_register_select,
    output var  logic [7:0]  io_sel_index
);
    ////////////////////////////////////////////////////////////////////
    logic [`SYNC_W-1:0] s1_r, s2_r, s3_r, st_r;
    logic               input_clock_pin_prev_r;
    logic [1:0]         ctrl_r;
    logic [7:0]         tidx_r;
    logic [`N_IN-1:0]   mt_r [`N_TERMS];
    logic [`N_IN-1:0]   mc_r [`N_TERMS];
    logic [23:0]        pol_r, regsel_r, ff_r, orv_r;
    logic [1:0]         mode_r [`N_CELLS];
    logic [1:0]         fb_r [`N_CELLS];
    logic [7:0]         pb_clksel_r, pb_clrsel_r, pbclk_prev_r;
    logic [23:0]        sum, pre, clr, clkev, oe, fbv, cellv, ff_nxt;
    logic [23:0]        pin_out_nxt, pin_oe_n_nxt;
    logic [`N_IN-1:0]   abus;
    logic [`N_TERMS-1:0] term;
    logic [31:0]        rd_nxt;
    wire  [23:0]        pin_st   = st_r[23:0];
    wire  [15:0]        addr_st  = st_r[55:40];
    wire                input_clock_pin_st = st_r[58];
    wire                rst_st   = st_r[59];
    wire                run      = ctrl_r[`CTRL_RUN];
    wire                crst     = ctrl_r[`CTRL_CRST] & rst_st;
    wire                input_clock_pin_rise = input_clock_pin_st & ~input_clock_pin_prev_r;
    wire                cfg_wr   = bus_wr & ~run;
    wire [7:0]          pidx_a   = bus_addr - `A_PCFG;
    wire [1:0]          pport    = pidx_a[5:4];
    wire                pcfg_hit = (bus_addr >= `A_PCFG) && (pidx_a < 8'h30)
                                   && (pidx_a[3:2] != 2'h3);
    wire                wr_ctrl  = bus_wr && (bus_addr == `A_CTRL);
    wire                wr_tidx  = cfg_wr && (bus_addr == `A_TIDX);
    wire                wr_pcfg  = cfg_wr && pcfg_hit;
    wire                wr_pbsel = cfg_wr && (bus_addr == `A_PBSEL);
    wire                tidx_ok  = tidx_r < 8'(`N_TERMS);
    wire                wr_mask  = cfg_wr && tidx_ok && (bus_addr >= `A_MASK0)
                                   && (bus_addr <= `A_MASK3);
    ////////////////////////////////////////////////////////////////////
    // pin inputs: three stages, a bit moves once stages two and three agree
    always_ff @(posedge mclk)
    begin
        s1_r <= {chip_select_in, reset_pin, input_clock_pin, wr_in, rd_in, addr_in,
                 port_d_in, port_c_in, port_e_in, port_b_in, port_a_in};
        s2_r <= s1_r;
        s3_r <= s2_r;
        st_r <= (st_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        input_clock_pin_prev_r <= input_clock_pin_st;
    end
    ////////////////////////////////////////////////////////////////////
    // shared input bus; address bits 2..7 never reach the arrays
    assign abus = {st_r[60:56], addr_st[15:8], addr_st[1:0], page_reg,
                   st_r[39:24], fbv};
    genvar t, c;
    generate
        for (t = 0; t < `N_TERMS; t++)
        begin : g_term
            // an unprogrammed term reads false
            assign term[t] = ((|mt_r[t]) | (|mc_r[t]))
                             & (&((~mt_r[t] | abus) & (~mc_r[t] | ~abus)));
        end
        for (c = 0; c < 8; c++)
        begin : g_cell
            assign sum[c] = |term[`T_PA_SUM + c*`PA_TERMS +: `PA_TERMS];
            assign pre[c] = term[`T_PORT_A_PRESET_TERM];
            assign clr[c] = term[`T_PA_CLR] | crst;
            assign clkev[c] = input_clock_pin_rise;
            assign oe[c] = term[`T_PORT_A_OUTPUT_ENABLE_TERM];
            assign sum[c+8] = |term[`T_PB_SUM + c*`PB_TERMS +: `PB_TERMS];
            assign pre[c+8] = term[`T_PB_PR + c];
            assign clr[c+8] = pb_clrsel_r[c] ? term[`T_PB_CLR + c] : crst;
            assign clkev[c+8] = pb_clksel_r[c] ? term[`T_PB_CLK + c] & ~pbclk_prev_r[c]
                                               : input_clock_pin_rise;
            assign oe[c+8] = term[`T_PB_OE + c];
            assign sum[c+16] = term[`T_PE_SUM + c];
            assign pre[c+16] = term[`T_PORT_E_PRESET_TERM];
            assign clr[c+16] = term[`T_PE_CLR] | crst;
            assign clkev[c+16] = input_clock_pin_rise;
            assign oe[c+16] = term[`T_PORT_E_OUTPUT_ENABLE_TERM];
        end
        for (c = 0; c < `N_CELLS; c++)
        begin : g_mc
            assign fbv[c] = (fb_r[c] == FB_REG)  ? ff_r[c] :
                            (fb_r[c] == FB_COMB) ? orv_r[c] : pin_st[c];
            assign cellv[c] = (regsel_r[c] ? ff_r[c] : orv_r[c]) ^ pol_r[c];
            // clear beats preset beats clock; stopped cells sit at zero
            assign ff_nxt[c] = !run ? 1'b0 : clr[c] ? 1'b0 : pre[c] ? 1'b1 :
                               clkev[c] ? sum[c] : ff_r[c];
            assign pin_out_nxt[c] = (mode_r[c] == PIN_BURIED) ? alt_out[c]
                                                               : cellv[c];
            // output and bidirectional pins both obey their enable term
            assign pin_oe_n_nxt[c] = !run ? 1'b1 :
                                     (mode_r[c] == PIN_OUT)    ? ~oe[c] :
                                     (mode_r[c] == PIN_BIDIR)  ? ~oe[c] :
                                     (mode_r[c] == PIN_BURIED) ? alt_oe_n[c] : 1'b1;
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////
    // macrocell flops, OR outputs and pins
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ff_r <= 24'h000000;
            orv_r <= 24'h000000;
            pbclk_prev_r <= 8'h00;
            pin_out <= 24'h000000;
            pin_oe_n <= 24'hFFFFFF;
        end
        else
        begin
            ff_r <= ff_nxt;
            orv_r <= run ? sum : 24'h000000;
            pbclk_prev_r <= term[`T_PB_CLK +: 8];
            pin_out <= pin_out_nxt;
            pin_oe_n <= pin_oe_n_nxt;
        end
    end
    // chip selects and io register decoder
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            select_out <= 8'h00;
            io_register_select <= 1'b0;
            io_sel_index <= 8'h00;
        end
        else
        begin
            select_out <= run ? term[`T_DEC +: 8] : 8'h00;
            io_register_select <= run & term[`T_IOSEL];
            io_sel_index <= addr_st[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ctrl_r <= `CTRL_RST;
            tidx_r <= 8'h00;
            pb_clksel_r <= 8'h00;
            pb_clrsel_r <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= bus_wdata[1:0];
            if (wr_tidx)
                tidx_r <= bus_wdata[7:0];
            if (wr_pbsel)
            begin
                pb_clksel_r <= bus_wdata[7:0];
                pb_clrsel_r <= bus_wdata[15:8];
            end
        end
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pol_r <= 24'h000000;
            regsel_r <= 24'h000000;
            for (int i = 0; i < `N_CELLS; i++)
            begin
                mode_r[i] <= PIN_IN;
                fb_r[i] <= FB_PIN;
            end
        end
        else if (wr_pcfg)
        begin
            for (int i = 0; i < 8; i++)
            begin
                case (pidx_a[3:2])
                    2'h0:
                    begin
                        pol_r[pport*8+i] <= bus_wdata[i];
                        regsel_r[pport*8+i] <= bus_wdata[8+i];
                    end
                    2'h1: mode_r[pport*8+i] <= bus_wdata[2*i +: 2];
                    2'h2: fb_r[pport*8+i] <= bus_wdata[2*i +: 2];
                    default: ;
                endcase
            end
        end
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int i = 0; i < `N_TERMS; i++)
            begin
                mt_r[i] <= '0;
                mc_r[i] <= '0;
            end
        end
        else if (wr_mask)
        begin
            case (bus_addr)
                `A_MASK0: mt_r[tidx_r][31:0] <= bus_wdata;
                `A_MASK1: mt_r[tidx_r][58:32] <= bus_wdata[26:0];
                `A_MASK2: mc_r[tidx_r][31:0] <= bus_wdata;
                default:  mc_r[tidx_r][58:32] <= bus_wdata[26:0];
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe, unmapped reads zero
    always_comb
    begin
        rd_nxt = 32'h00000000;
        case (bus_addr)
            `A_CTRL:  rd_nxt = {30'h0, ctrl_r};
            `A_TIDX:  rd_nxt = {24'h0, tidx_r};
            `A_MASK0: rd_nxt = tidx_ok ? mt_r[tidx_r][31:0] : 32'h0;
            `A_MASK1: rd_nxt = tidx_ok ? {5'h0, mt_r[tidx_r][58:32]} : 32'h0;
            `A_MASK2: rd_nxt = tidx_ok ? mc_r[tidx_r][31:0] : 32'h0;
            `A_MASK3: rd_nxt = tidx_ok ? {5'h0, mc_r[tidx_r][58:32]} : 32'h0;
            `A_PBSEL: rd_nxt = {16'h0, pb_clrsel_r, pb_clksel_r};
            `A_STAT:  rd_nxt = {23'h0, io_register_select, select_out};
            `A_CELLS: rd_nxt = {8'h0, ff_r};
            default:
            begin
                if (pcfg_hit)
                begin
                    for (int i = 0; i < 8; i++)
                    begin
                        case (pidx_a[3:2])
                            2'h0:
                            begin
                                rd_nxt[i] = pol_r[pport*8+i];
                                rd_nxt[8+i] = regsel_r[pport*8+i];
                            end
                            2'h1: rd_nxt[2*i +: 2] = mode_r[pport*8+i];
                            default: rd_nxt[2*i +: 2] = fb_r[pport*8+i];
                        endcase
                    end
                end
            end
        endcase
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            bus_rdata <= 32'h00000000;
        else
            bus_rdata <= bus_rd ? rd_nxt : 32'h00000000;
    end
    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [23:0] in_mask;
    always_comb
    begin
        for (int i = 0; i < `N_CELLS; i++)
            in_mask[i] = (mode_r[i] == PIN_IN);
    end
    AST_CFG_FROZEN: assert property (run && bus_wr && bus_addr != `A_CTRL
        |=> $stable(pol_r) && $stable(pb_clksel_r) && $stable(tidx_r))
        else $error("configuration changed while running");
    // port A flops, configurable reset of ports A and E
    AST_PA_HOLD: assert property (run && !input_clock_pin_rise && !term[`T_PORT_A_PRESET_TERM]
        && !clr[0] |=> $stable(ff_r[7:0]))
        else $error("port A flop moved without clock pin edge");
    AST_PA_PRESET: assert property (run && term[`T_PORT_A_PRESET_TERM] && !clr[0]
        |=> ff_r[7:0] == 8'hFF)
        else $error("port A preset term failed");
    AST_PA_CLEAR: assert property (run && term[`T_PA_CLR] |=> ff_r[7:0] == 8'h00)
        else $error("port A clear term failed");
    AST_CELL_RESET: assert property (run && crst ##1 run
        |-> ff_r[7:0] == 8'h00 && ff_r[23:16] == 8'h00)
        else $error("configurable reset did not clear");
    // port E flops
    AST_PE_CLEAR: assert property (run && term[`T_PE_CLR] |=> ff_r[23:16] == 8'h00)
        else $error("port E clear term failed");
    AST_PE_PRESET: assert property (run && term[`T_PORT_E_PRESET_TERM] && !clr[16]
        |=> ff_r[23:16] == 8'hFF)
        else $error("port E preset term failed");
    AST_PE_HOLD: assert property (run && !input_clock_pin_rise && !term[`T_PORT_E_PRESET_TERM]
        && !clr[16] |=> $stable(ff_r[23:16]))
        else $error("port E flop moved without clock pin edge");
    // pin drive
    AST_INPUT_OE: assert property ($stable(in_mask) [*2]
        |-> (pin_oe_n & in_mask) == in_mask)
        else $error("input-mode pin driven");
    AST_STOP_OE: assert property (!run |=> pin_oe_n == 24'hFFFFFF)
        else $error("pin driven while stopped");
    AST_OUT_DRIVE: assert property (run && mode_r[8] == PIN_OUT && oe[8]
        |=> !pin_oe_n[8])
        else $error("output pin not driven with its enable term");
    AST_BURIED: assert property (run && mode_r[16] == PIN_BURIED
        |=> pin_out[16] == $past(alt_out[16]) && pin_oe_n[16] == $past(alt_oe_n[16]))
        else $error("buried cell pin not handed to other function");
    // decoder and port B
    AST_IO_SEL: assert property (run && term[`T_IOSEL]
        |=> io_register_select && io_sel_index == $past(addr_st[7:0]))
        else $error("io register select wrong");
    AST_PB_TCLK: assert property (run && pb_clksel_r[0] && !clkev[8]
        && !pre[8] && !clr[8] |=> $stable(ff_r[8]))
        else $error("port B cell moved without its term clock");
    AST_PB_PRESET: assert property (run && pre[8] && !clr[8] |=> ff_r[8])
        else $error("port B preset failed");
    AST_PB_RST_CLR: assert property (run && !pb_clrsel_r[0] && crst |=> !ff_r[8])
        else $error("port B cell ignored configurable reset");
    AST_PB_OWN_CLR: assert property (run && pb_clrsel_r[0] && term[`T_PB_CLR]
        |=> !ff_r[8])
        else $error("port B own clear term failed");
    AST_DEC_OUT: assert property (!run |=> select_out == 8'h00 && !io_register_select)
        else $error("selects active while stopped");
    // main scenarios
    COV_PRESET: cover property (run && term[`T_PORT_A_PRESET_TERM]);
    COV_IOSEL: cover property (run && term[`T_IOSEL] ##1 io_register_select);
    COV_PBCLK: cover property (run && pb_clksel_r[0] && clkev[8]);
    COV_BIDIR: cover property (mode_r[0] == PIN_BIDIR && !pin_oe_n[0]);
    COV_PE_PRESET: cover property (run && term[`T_PORT_E_PRESET_TERM]);
endmodule : plc_core
`default_nettype wire

// ==== src/plc_defs.svh ====
// constants of the address decode and macrocell block
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
`define N_IN 59
`define N_TERMS 182
`define N_CELLS 24
`define SYNC_W 61
// term index map
`define T_DEC 0
`define T_IOSEL 7
`define T_PA_SUM 8
`define PA_TERMS 6
`define T_PORT_A_OUTPUT_ENABLE_TERM 56
`define T_PORT_A_PRESET_TERM 57
`define T_PA_CLR 58
`define T_PB_SUM 59
`define PB_TERMS 10
`define T_PB_PR 139
`define T_PB_CLR 147
`define T_PB_CLK 155
`define T_PB_OE 163
`define T_PE_SUM 171
`define T_PORT_E_OUTPUT_ENABLE_TERM 179
`define T_PORT_E_PRESET_TERM 180
`define T_PE_CLR 181
// register byte addresses
`define A_CTRL 8'h00
`define A_TIDX 8'h04
`define A_MASK0 8'h08
`define A_MASK1 8'h0C
`define A_MASK2 8'h10
`define A_MASK3 8'h14
`define A_PCFG 8'h20
`define A_PBSEL 8'h50
`define A_STAT 8'h54
`define A_CELLS 8'h58
// ctrl fields and reset value
`define CTRL_RUN 0
`define CTRL_CRST 1
`define CTRL_RST 2'h0
`endif

// ==== src/plc_pkg.sv ====
// types of the address decode and macrocell block
package plc_pkg;
    typedef enum logic [1:0] {PIN_IN, PIN_OUT, PIN_BIDIR, PIN_BURIED} pin_mode_t;
    typedef enum logic [1:0] {FB_PIN, FB_REG, FB_COMB, FB_NONE} fb_sel_t;
endpackage : plc_pkg

// ==== sim/pin_world.sv ====
// external pins of ports A, B and E with pull-ups and an outside driver
`timescale 1ns/10ps
`default_nettype none
module pin_world
(
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe_n,
    input  wire logic [23:0] ext_val,
    input  wire logic [23:0] ext_en,
    output var  logic [23:0] pin_level
);
    // block drive wins, then the outside driver, else the pull-up holds the pin high
    always_comb
    begin
        pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
    end
endmodule : pin_world
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench of the decode and macrocell block
`timescale 1ns/10ps
`default_nettype none
`include "plc_defs.svh"
module tb;
    logic        mclk      = 1'b0;
    logic        reset     = 1'b1;
    logic [7:0]  bus_addr  = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_wr    = 1'b0;
    logic        bus_rd    = 1'b0;
    logic [7:0]  port_c_in = 8'h00;
    logic [7:0]  port_d_in = 8'h00;
    logic [15:0] addr_in   = 16'h0000;
    logic        clk_pin   = 1'b0;
    logic        rst_pin   = 1'b0;
    logic [23:0] alt_out   = 24'h000000;
    logic [23:0] alt_oe_n  = 24'hFFFFFF;
    logic [23:0] ext_val   = 24'h000000;
    logic [23:0] ext_en    = 24'h000000;
    logic [31:0] bus_rdata;
    logic [23:0] pin_out;
    logic [23:0] pin_oe_n;
    logic [23:0] pin_level;
    logic [7:0]  select_out;
    logic [7:0]  io_sel_index;
    logic        io_register_select;
    int          fails        = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    always #5 mclk = ~mclk;

    pin_world i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
                      .ext_en(ext_en), .pin_level(pin_level));

    plc_core i_dut (
        .mclk(mclk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .port_a_in(pin_level[7:0]), .port_b_in(pin_level[15:8]),
        .port_e_in(pin_level[23:16]), .port_c_in(port_c_in), .port_d_in(port_d_in),
        .addr_in(addr_in), .rd_in(1'b0), .wr_in(1'b0), .input_clock_pin(clk_pin),
        .reset_pin(rst_pin), .chip_select_in(1'b0), .page_reg(4'h0),
        .alt_out(alt_out), .alt_oe_n(alt_oe_n), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .select_out(select_out),
        .io_register_select(io_register_select), .io_sel_index(io_sel_index));

    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge mclk);
        bus_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd   <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask : rd

    task automatic term(input logic [7:0] idx, input logic [58:0] t, input logic [58:0] c);
        wr(`A_TIDX, {24'h0, idx});
        wr(`A_MASK0, t[31:0]);
        wr(`A_MASK1, {5'h00, t[58:32]});
        wr(`A_MASK2, c[31:0]);
        wr(`A_MASK3, {5'h00, c[58:32]});
    endtask : term

    // pins pass a 3-flop sync, the array and up to two output registers
    task automatic settle;
        repeat (10) @(posedge mclk);
        #1;
    endtask : settle

    task automatic pulse;
        @(posedge mclk) clk_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        clk_pin <= 1'b0;
        settle();
    endtask : pulse

    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`A_CTRL, 32'h0);
        rd(`A_STAT, 32'h0);
        rd(8'hFC, 32'h0);
        chk({8'h00, pin_oe_n}, 32'h00FFFFFF);
    endtask : t_reset

    task automatic t_decode;
        term(8'h00, 59'h1 << 53, 59'h1 << 44);
        term(8'h07, 59'h1 << 46, 59'h0);
        wr(`A_CTRL, 32'h1);
        @(posedge mclk) addr_in <= 16'h80FC;
        settle();
        chk({io_register_select, select_out}, 32'h1);
        @(posedge mclk) addr_in <= 16'h8135;
        settle();
        chk({io_register_select, select_out, io_sel_index}, 32'h18035);
        rd(`A_STAT, 32'h180);
        term(8'h07, 59'h0, 59'h0);
        settle();
        chk({io_register_select, select_out}, 32'h180);
    endtask : t_decode

    task automatic t_port_a;
        wr(`A_CTRL, 32'h0);
        term(8'h08, 59'h1 << 24, 59'h0);
        term(8'h38, 59'h1 << 32, 59'h0);
        term(8'h39, 59'h1 << 33, 59'h0);
        term(8'h3A, 59'h1 << 34, 59'h0);
        wr(`A_PCFG + 8'h04, 32'h1);
        wr(`A_PCFG, 32'h1);
        wr(`A_CTRL, 32'h1);
        @(posedge mclk) port_c_in <= 8'h01;
        port_d_in <= 8'h01;
        settle();
        chk({pin_oe_n[0], pin_out[0]}, 32'h0);
        @(posedge mclk) port_c_in <= 8'h00;
        port_d_in <= 8'h00;
        settle();
        chk({pin_oe_n[0], pin_out[0]}, 32'h3);
        wr(`A_CTRL, 32'h0);
        wr(`A_PCFG, 32'h100);
        wr(`A_CTRL, 32'h1);
        @(posedge mclk) port_c_in <= 8'h01;
        port_d_in <= 8'h01;
        settle();
        chk(pin_out[0], 1'b0);
        pulse();
        chk(pin_out[0], 1'b1);
        @(posedge mclk) port_d_in <= 8'h05;
        settle();
        chk(pin_out[0], 1'b0);
        @(posedge mclk) port_d_in <= 8'h03;
        settle();
        chk(pin_out[0], 1'b1);
        @(posedge mclk) port_d_in <= 8'h01;
        wr(`A_CTRL, 32'h3);
        rst_pin <= 1'b1;
        settle();
        chk(pin_out[0], 1'b0);
        @(posedge mclk) rst_pin <= 1'b0;
    endtask : t_port_a

    task automatic t_port_b;
        wr(`A_CTRL, 32'h0);
        term(8'h3B, 59'h1 << 25, 59'h0);
        term(8'h9B, 59'h1 << 35, 59'h0);
        term(8'h93, 59'h1 << 36, 59'h0);
        term(8'hA3, 59'h1 << 32, 59'h0);
        wr(`A_PCFG + 8'h14, 32'h1);
        wr(`A_PCFG + 8'h10, 32'h100);
        wr(`A_PBSEL, 32'h101);
        wr(`A_CTRL, 32'h1);
        @(posedge mclk) port_c_in <= 8'h02;
        pulse();
        chk(pin_out[8], 1'b0);
        @(posedge mclk) port_d_in <= 8'h09;
        settle();
        chk({pin_oe_n[8], pin_out[8]}, 32'h1);
        @(posedge mclk) port_d_in <= 8'h11;
        settle();
        chk(pin_out[8], 1'b0);
    endtask : t_port_b

    task automatic t_port_e;
        wr(`A_CTRL, 32'h0);
        term(8'hAB, 59'h1 << 26, 59'h0);
        term(8'hB3, 59'h1 << 32, 59'h0);
        term(8'hB4, 59'h1 << 38, 59'h0);
        term(8'hB5, 59'h1 << 37, 59'h0);
        wr(`A_PCFG + 8'h24, 32'h1);
        wr(`A_CTRL, 32'h1);
        @(posedge mclk) port_c_in <= 8'h04;
        settle();
        chk({pin_oe_n[16], pin_out[16]}, 32'h1);
        @(posedge mclk) port_d_in <= 8'h00;
        settle();
        chk(pin_oe_n[16], 1'b1);
        // shared preset sets all eight port E flops, clear wins over preset
        @(posedge mclk) port_d_in <= 8'h40;
        settle();
        rd(`A_CELLS, 32'h00FF0000);
        @(posedge mclk) port_d_in <= 8'h60;
        settle();
        rd(`A_CELLS, 32'h00000000);
    endtask : t_port_e

    // cell 1 input, cell 2 buried expander, cell 3 output fed by cell 2
    task automatic t_pins;
        wr(`A_CTRL, 32'h0);
        term(8'h00, 59'h1 << 1, 59'h0);
        term(8'h14, 59'h1 << 27, 59'h0);
        term(8'h1A, 59'h1 << 2, 59'h0);
        wr(`A_PCFG + 8'h04, 32'h70);
        wr(`A_PCFG + 8'h08, 32'h20);
        wr(`A_PCFG, 32'h0);
        wr(`A_CTRL, 32'h1);
        @(posedge mclk) port_d_in <= 8'h01;
        port_c_in <= 8'h08;
        alt_out <= 24'h000004;
        alt_oe_n <= 24'hFFFFFB;
        ext_en <= 24'h000002;
        ext_val <= 24'h000002;
        settle();
        chk(select_out[0], 1'b1);
        chk({pin_oe_n[3:1], pin_out[3:2]}, 32'h07);
    endtask : t_pins

    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_decode();
        t_port_a();
        t_port_b();
        t_port_e();
        t_pins();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
